// *** core/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned RES_W  = 12;

    localparam logic [ADDR_W-1:0] OFS_CTRL0   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CTRL1   = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_TRIG    = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_DELAY   = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_RESULT  = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_HIBOUND = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_LOBOUND = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_IRQ     = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_PINSEL  = 12'h020;

    // Control zero fields.
    localparam int unsigned C0_START = 7;
    localparam int unsigned C0_BUSY  = 6;
    localparam int unsigned C0_PWR   = 5;
    localparam int unsigned C0_FMT   = 4;
    localparam int unsigned C0_CH_LO = 0;
    // Control one fields.
    localparam int unsigned C1_SRC_LO = 4;
    localparam int unsigned C1_CK_LO  = 0;
    // Trigger control fields.
    localparam int unsigned TR_SEL  = 0;
    localparam int unsigned TR_DLY  = 1;
    localparam int unsigned TR_HIVE = 2;
    localparam int unsigned TR_LOVE = 3;
    // Interrupt register fields.
    localparam int unsigned IR_GIE  = 0;
    localparam int unsigned IR_ADE  = 1;
    localparam int unsigned IR_LIME = 2;
    localparam int unsigned IR_MFE  = 3;
    localparam int unsigned IR_ADF  = 4;
    localparam int unsigned IR_LIMF = 5;

    localparam int unsigned SAMPLE_CLKS  = 4;
    localparam int unsigned CONVERT_CLKS = 12;
    localparam int unsigned TOTAL_CLKS   = SAMPLE_CLKS + CONVERT_CLKS;

    localparam logic [2:0] SRC_EXT0 = 3'h0;
    localparam logic [2:0] SRC_AMP  = 3'h1;
    localparam logic [2:0] SRC_GND0 = 3'h2;
    localparam logic [2:0] SRC_GND1 = 3'h3;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {SEL_NONE, SEL_EXT, SEL_AMP, SEL_GND} mux_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        mux_sel_t   sel;
        logic [3:0] channel;
        logic       float_in;
        logic       power_on;
    } analog_ctl_t;

endpackage

// *** core/adc_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_divider
    import adc_ctrl_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [2:0] div_sel_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [6:0] cnt;
    } div_state_t;

    div_state_t st_reg;
    div_state_t st_next;

    function automatic logic [6:0] div_limit(input logic [2:0] s);
        div_limit = 7'((8'h01 << s) - 8'h01);
    endfunction

    // Division by 2**sel derives the converter clock enable.
    always_comb begin
        st_next = st_reg;
        tick_o  = 1'b0;
        if (!run_i) begin
            st_next.cnt = 7'h00;
        end else if (st_reg.cnt >= div_limit(div_sel_i)) begin
            st_next.cnt = 7'h00;
            tick_o      = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 7'h01;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// *** core/adc_input_and_conversion_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_input_and_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned PINS = 8
)(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire apb_req_t          apb_req_i,
    output apb_rsp_t               apb_rsp_o,
    input  wire logic              pwm_event_i,
    input  wire logic [RES_W-1:0]  sar_data_i,
    input  wire logic [PINS-1:0]   port_dir_in_i,
    input  wire logic [PINS-1:0]   pullup_en_i,
    output analog_ctl_t            analog_ctl_o,
    output logic                   sample_o,
    output logic [PINS-1:0]        pin_analog_o,
    output logic [PINS-1:0]        pin_digital_en_o,
    output logic [PINS-1:0]        pin_out_en_n_o,
    output logic [PINS-1:0]        pullup_on_o,
    output logic                   irq_o
);
    initial begin
        if (PINS < 1 || PINS > 16) begin
            $error("PINS must be between 1 and 16.");
        end
    end

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONVERT} phase_t;

    typedef struct packed {
        phase_t            phase;
        logic [4:0]        clk_cnt;
        logic [7:0]        dly_cnt;
        logic [7:0]        ctrl0;
        logic [7:0]        ctrl1;
        logic [3:0]        trig;
        logic [7:0]        delay;
        logic [RES_W-1:0]  result;
        logic [RES_W-1:0]  hi_bound;
        logic [RES_W-1:0]  lo_bound;
        logic [3:0]        irq_en;
        logic              adf;
        logic              limf;
        logic              start_seen;
        logic              amp_conv;
        logic [PINS-1:0]   pin_sel;
        logic [31:0]       rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic   adc_tick;

    ////////////////////////////////////////////////////////////////////////
    adc_divider u_div (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (st_reg.phase == ST_SAMPLE || st_reg.phase == ST_CONVERT),
        .div_sel_i (st_reg.ctrl1[C1_CK_LO +: 3]),
        .tick_o    (adc_tick)
    );

    // Right-aligned when format bit is set, else left-aligned in 16 bits.
    function automatic logic [15:0] align(input logic [RES_W-1:0] v,
                                          input logic fmt);
        align = fmt ? {4'h0, v} : {v, 4'h0};
    endfunction

    function automatic mux_sel_t route(input logic [2:0] src,
                                       input logic [3:0] ch);
        if (src == SRC_AMP) begin
            route = SEL_AMP;
        end else if (src == SRC_GND0 || src == SRC_GND1) begin
            route = SEL_GND;
        end else if (ch[3] || ch == 4'h1 || ch == 4'h5) begin
            route = SEL_NONE;
        end else begin
            route = SEL_EXT;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic       access;
    logic       wr;
    logic [2:0] src;
    logic       start_req;
    logic       done;
    logic       exceed;
    logic       hit_hi;
    logic       hit_lo;

    assign access = apb_req_i.psel && apb_req_i.penable;
    assign wr     = access && apb_req_i.pwrite;
    assign src    = st_reg.ctrl1[C1_SRC_LO +: 3];
    assign done   = st_reg.phase == ST_CONVERT && adc_tick
                    && st_reg.clk_cnt == 5'(TOTAL_CLKS - 1);
    assign hit_hi = st_reg.trig[TR_HIVE] && sar_data_i > st_reg.hi_bound;
    assign hit_lo = st_reg.trig[TR_LOVE] && sar_data_i < st_reg.lo_bound;
    assign exceed = done && st_reg.amp_conv && (hit_hi || hit_lo);

    always_comb begin
        logic [7:0] c0_w;
        c0_w      = apb_req_i.pwdata[7:0];
        st_next   = st_reg;
        start_req = 1'b0;
        // Start fires on the falling edge of the start bit after a rise.
        if (wr && apb_req_i.paddr == OFS_CTRL0) begin
            if (c0_w[C0_START]) begin
                st_next.start_seen = 1'b1;
            end else if (st_reg.start_seen) begin
                st_next.start_seen = 1'b0;
                start_req = !st_reg.trig[TR_SEL];
            end
            st_next.ctrl0 = {c0_w[7], st_reg.ctrl0[C0_BUSY], c0_w[5:0]};
        end
        if (pwm_event_i && st_reg.trig[TR_SEL]) begin
            start_req = 1'b1;
        end
        if (wr) begin
            case (apb_req_i.paddr)
                OFS_CTRL1:   st_next.ctrl1 = apb_req_i.pwdata[7:0];
                OFS_TRIG:    st_next.trig = apb_req_i.pwdata[3:0];
                OFS_DELAY:   st_next.delay = apb_req_i.pwdata[7:0];
                OFS_HIBOUND: st_next.hi_bound = st_reg.ctrl0[C0_FMT]
                    ? apb_req_i.pwdata[RES_W-1:0]
                    : apb_req_i.pwdata[15:4];
                OFS_LOBOUND: st_next.lo_bound = st_reg.ctrl0[C0_FMT]
                    ? apb_req_i.pwdata[RES_W-1:0]
                    : apb_req_i.pwdata[15:4];
                OFS_IRQ: begin
                    st_next.irq_en = apb_req_i.pwdata[3:0];
                    if (!apb_req_i.pwdata[IR_ADF]) st_next.adf = 1'b0;
                    if (!apb_req_i.pwdata[IR_LIMF]) st_next.limf = 1'b0;
                end
                OFS_PINSEL:  st_next.pin_sel = apb_req_i.pwdata[PINS-1:0];
                default: ;
            endcase
        end
        case (st_reg.phase)
            ST_IDLE: begin
                st_next.clk_cnt = 5'h00;
                if (start_req && st_reg.ctrl0[C0_PWR]) begin
                    st_next.amp_conv = src == SRC_AMP;
                    if (st_reg.trig[TR_SEL] && st_reg.trig[TR_DLY]
                        && st_reg.delay != 8'h00) begin
                        st_next.dly_cnt = st_reg.delay - 8'h01;
                        st_next.phase   = ST_DELAY;
                    end else begin
                        st_next.phase = ST_SAMPLE;
                    end
                    st_next.ctrl0[C0_BUSY] = 1'b1;
                end
            end
            ST_DELAY: begin
                // Each idle cycle here is one system clock of delay.
                if (st_reg.dly_cnt == 8'h00) begin
                    st_next.phase = ST_SAMPLE;
                end else begin
                    st_next.dly_cnt = st_reg.dly_cnt - 8'h01;
                end
            end
            ST_SAMPLE: begin
                if (adc_tick) begin
                    st_next.clk_cnt = st_reg.clk_cnt + 5'h01;
                    if (st_reg.clk_cnt == 5'(SAMPLE_CLKS - 1)) begin
                        st_next.phase = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                if (adc_tick) begin
                    st_next.clk_cnt = st_reg.clk_cnt + 5'h01;
                end
                if (done) begin
                    st_next.result = sar_data_i;
                    st_next.ctrl0[C0_BUSY] = 1'b0;
                    st_next.adf = 1'b1;
                    st_next.phase = ST_IDLE;
                end
            end
            default: st_next.phase = ST_IDLE;
        endcase
        // Busy phases ignore new starts; power-down aborts.
        if (!st_reg.ctrl0[C0_PWR] && st_reg.phase != ST_IDLE) begin
            st_next.phase = ST_IDLE;
            st_next.ctrl0[C0_BUSY] = 1'b0;
        end
        if (exceed) begin
            st_next.limf = 1'b1;
        end
        st_next.rdata = ZERO_WORD;
        if (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite) begin
            case (apb_req_i.paddr)
                OFS_CTRL0:   st_next.rdata = {24'h0, st_reg.ctrl0};
                OFS_CTRL1:   st_next.rdata = {24'h0, st_reg.ctrl1};
                OFS_TRIG:    st_next.rdata = {28'h0, st_reg.trig};
                OFS_DELAY:   st_next.rdata = {24'h0, st_reg.delay};
                OFS_RESULT:  st_next.rdata = {16'h0,
                    align(st_reg.result, st_reg.ctrl0[C0_FMT])};
                OFS_HIBOUND: st_next.rdata = {16'h0,
                    align(st_reg.hi_bound, st_reg.ctrl0[C0_FMT])};
                OFS_LOBOUND: st_next.rdata = {16'h0,
                    align(st_reg.lo_bound, st_reg.ctrl0[C0_FMT])};
                OFS_IRQ:     st_next.rdata = {26'h0, st_reg.limf,
                    st_reg.adf, st_reg.irq_en};
                OFS_PINSEL:  st_next.rdata = 32'(st_reg.pin_sel);
                default:     st_next.rdata = ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data is captured in the setup cycle, so access phase is one cycle.
    logic mapped;
    assign mapped = apb_req_i.paddr[1:0] == 2'b00
                    && apb_req_i.paddr <= OFS_PINSEL;
    assign apb_rsp_o.prdata  = st_reg.rdata;
    assign apb_rsp_o.pready  = 1'b1;
    assign apb_rsp_o.pslverr = access && !mapped;

    always_comb begin
        analog_ctl_o.sel      = route(src, st_reg.ctrl0[C0_CH_LO +: 4]);
        analog_ctl_o.channel  = st_reg.ctrl0[C0_CH_LO +: 4];
        analog_ctl_o.float_in = analog_ctl_o.sel == SEL_NONE;
        analog_ctl_o.power_on = st_reg.ctrl0[C0_PWR];
    end
    assign sample_o         = st_reg.phase == ST_SAMPLE;
    assign pin_analog_o     = st_reg.pin_sel;
    assign pin_digital_en_o = ~st_reg.pin_sel;
    // Analog pins never drive, whatever the port direction says.
    assign pin_out_en_n_o   = port_dir_in_i | st_reg.pin_sel;
    assign pullup_on_o      = pullup_en_i & ~st_reg.pin_sel;
    assign irq_o = st_reg.irq_en[IR_GIE] && st_reg.irq_en[IR_MFE]
                   && ((st_reg.irq_en[IR_ADE] && st_reg.adf)
                   || (st_reg.irq_en[IR_LIME] && st_reg.limf));

    ////////////////////////////////////////////////////////////////////////
    sequence s_started;
        st_reg.phase == ST_IDLE && start_req && st_reg.ctrl0[C0_PWR];
    endsequence

    property p_busy_set;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_started |=> st_reg.ctrl0[C0_BUSY];
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("Busy not set after start.");

    property p_done_flags;
        @(posedge sys_clk_i) disable iff (rst_i)
        done && st_reg.ctrl0[C0_PWR] |=> st_reg.adf && !st_reg.ctrl0[C0_BUSY]
            && st_reg.result == $past(sar_data_i);
    endproperty
    a_done_flags: assert property (p_done_flags)
        else $error("Completion did not set flag and result.");

    property p_sample_len;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(st_reg.phase == ST_CONVERT) |-> st_reg.clk_cnt == 5'd4;
    endproperty
    a_sample_len: assert property (p_sample_len)
        else $error("Sampling did not last four clocks.");

    property p_ignore_busy;
        @(posedge sys_clk_i) disable iff (rst_i)
        st_reg.phase == ST_CONVERT && !done && st_reg.ctrl0[C0_PWR]
            |=> st_reg.phase == ST_CONVERT;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy)
        else $error("Conversion disturbed while busy.");

    property p_pullup;
        @(posedge sys_clk_i) disable iff (rst_i)
        (pin_analog_o & pullup_on_o) == '0
            && (pin_analog_o & ~pin_out_en_n_o) == '0;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("Analog pin still pulled up or driven.");

    property p_route_amp;
        @(posedge sys_clk_i) disable iff (rst_i)
        src == SRC_AMP |-> analog_ctl_o.sel == SEL_AMP;
    endproperty
    a_route_amp: assert property (p_route_amp)
        else $error("Amplifier source not routed.");

    property p_limit;
        @(posedge sys_clk_i) disable iff (rst_i)
        exceed |=> st_reg.limf;
    endproperty
    a_limit: assert property (p_limit)
        else $error("Boundary flag not set.");

    property p_irq;
        @(posedge sys_clk_i) disable iff (rst_i)
        irq_o |-> st_reg.irq_en[IR_GIE] && st_reg.irq_en[IR_MFE];
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt without enables.");

    property p_delay;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(st_reg.phase == ST_DELAY) |->
            st_reg.dly_cnt == $past(st_reg.delay) - 8'h01;
    endproperty
    a_delay: assert property (p_delay)
        else $error("Delay count not loaded.");
endmodule
`default_nettype wire

// *** testbench/analog_front_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
    import adc_ctrl_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire analog_ctl_t      analog_ctl_i,
    input  wire logic [RES_W-1:0] amp_level_i,
    output logic [RES_W-1:0]      sar_data_o
);
    // A floating or unpowered input settles nowhere, so the model shows a
    // code that moves every cycle rather than a value a bench could trust.
    logic [RES_W-1:0] noise_reg;
    initial noise_reg = 12'h5A3;
    always_ff @(posedge sys_clk_i) begin
        noise_reg <= noise_reg + 12'h9D7;
    end
    ////////////////////////////////////////////////////////////////////
    always_comb begin
        case (analog_ctl_i.sel)
            SEL_EXT: sar_data_o = analog_ctl_i.float_in ? noise_reg
                                  : {analog_ctl_i.channel, 8'hA5};
            SEL_AMP: sar_data_o = amp_level_i;
            SEL_GND: sar_data_o = 12'h000;
            default: sar_data_o = noise_reg;
        endcase
        if (!analog_ctl_i.power_on) begin
            sar_data_o = noise_reg;
        end
    end
endmodule
`default_nettype wire

// *** testbench/test_adc_input_and_conversion_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_adc_input_and_conversion_control
    import adc_ctrl_pkg::*;
;
    logic             sys_clk;
    logic             rst;
    apb_req_t         req;
    apb_rsp_t         rsp;
    logic             pwm_ev;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] amp;
    logic [7:0]       dir;
    logic [7:0]       pull;
    analog_ctl_t      actl;
    logic             smp;
    logic [7:0]       p_an;
    logic [7:0]       p_dig;
    logic [7:0]       p_oen_n;
    logic [7:0]       p_pu;
    logic             irq;
    int               bad_count;
    int               checks;
    logic [31:0]      rdat;
    logic             err;
    int               n;
    int               dly;
    logic [3:0]       ch;
    logic [7:0]       ps;
    logic [7:0]       e8;
    logic [31:0]      bnd;
    localparam logic [3:0]  CHS [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
    localparam logic [31:0] IRQW [5] = '{32'h1B, 32'h13, 32'h1A,
                                         32'h19, 32'h0B};

    adc_input_and_conversion_control #(.PINS(8))
        adc_input_and_conversion_control_inst (
        .sys_clk_i(sys_clk), .rst_i(rst), .apb_req_i(req), .apb_rsp_o(rsp),
        .pwm_event_i(pwm_ev), .sar_data_i(sar), .port_dir_in_i(dir),
        .pullup_en_i(pull), .analog_ctl_o(actl), .sample_o(smp),
        .pin_analog_o(p_an), .pin_digital_en_o(p_dig),
        .pin_out_en_n_o(p_oen_n), .pullup_on_o(p_pu), .irq_o(irq));

    analog_front_model analog_front_model_inst (
        .sys_clk_i(sys_clk), .analog_ctl_i(actl), .amp_level_i(amp),
        .sar_data_o(sar));

    ////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    function automatic logic [31:0] exp_res(input logic f,
                                            input logic [11:0] v);
        return f ? {20'h0_0000, v} : {16'h0000, v, 4'h0};
    endfunction

    // One idle edge before each setup keeps psel from being written twice
    // in one time step when transfers follow each other.
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int w;
        w = 0;
        @(posedge sys_clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        @(posedge sys_clk);
        while (rsp.pready !== 1'b1 && w < 50) begin
            w++;
            @(posedge sys_clk);
        end
        if (w == 50) bad_count++;
        rdat = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic conv(input logic [7:0] c0, input int dv);
        int k;
        k = 0;
        bus(1'b1, OFS_CTRL0, 32'(c0));
        bus(1'b1, OFS_CTRL0, 32'(c0) | 32'h0000_0080);
        bus(1'b1, OFS_CTRL0, 32'(c0));
        while (smp !== 1'b1 && k < 8) begin
            k++;
            @(posedge sys_clk);
        end
        n = 0;
        while (smp === 1'b1 && n < 2000) begin
            n++;
            @(posedge sys_clk);
        end
        chk("sample_len", 32'(4 << dv), 32'(n));
        bus(1'b1, OFS_CTRL0, 32'(c0) | 32'h0000_0080);
        bus(1'b1, OFS_CTRL0, 32'(c0));
        rdat = 32'h0000_0040;
        k = 0;
        while (rdat[C0_BUSY] !== 1'b0 && k < 500) begin
            bus(1'b0, OFS_CTRL0, ZERO_WORD);
            k++;
        end
        chk("busy_done", 32'h0, 32'(rdat[C0_BUSY]));
        repeat (40) @(posedge sys_clk);
        bus(1'b0, OFS_CTRL0, ZERO_WORD);
        chk("busy_again", 32'h0, 32'(rdat[C0_BUSY]));
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        pwm_ev = 1'b0;
        amp = 12'h000;
        dir = 8'h00;
        pull = 8'h00;
        bad_count = 0;
        checks = 0;
        rdat = $urandom(56);
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, OFS_CTRL0, ZERO_WORD);
        chk("ctrl0_reset", 32'h0, rdat);
        bus(1'b0, 12'h040, ZERO_WORD);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rdat);
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, OFS_CTRL1, 32'(s) << C1_SRC_LO);
            @(negedge sys_clk);
            chk("source", (s == 1) ? 32'(SEL_AMP) : (s == 2 || s == 3) ?
                32'(SEL_GND) : 32'(SEL_EXT), 32'(actl.sel));
        end
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, OFS_CTRL0, 32'h0000_0020 | 32'(c));
            @(negedge sys_clk);
            // Codes one and five name no channel either, so they float.
            chk("float", 32'(c[3] || c == 1 || c == 5),
                32'(actl.float_in));
            chk("channel", 32'(c), 32'(actl.channel));
            chk("power", 32'h1, 32'(actl.power_on));
        end
        repeat (4) begin
            ps = 8'($urandom());
            @(posedge sys_clk);
            dir <= 8'($urandom());
            pull <= 8'($urandom());
            bus(1'b1, OFS_PINSEL, 32'(ps));
            @(negedge sys_clk);
            chk("pin_analog", 32'(ps), 32'(p_an));
            e8 = ~ps;
            chk("pin_digital", 32'(e8), 32'(p_dig));
            e8 = pull & ~ps;
            chk("pullup", 32'(e8), 32'(p_pu));
            e8 = dir | ps;
            chk("out_en_n", 32'(e8), 32'(p_oen_n));
        end
        for (int dv = 0; dv < 3; dv++) begin
            ch = CHS[$urandom_range(5)];
            bus(1'b1, OFS_CTRL1, 32'(dv));
            conv({2'b00, 1'b1, dv[0], ch}, dv);
            bus(1'b0, OFS_RESULT, ZERO_WORD);
            chk("result", exp_res(dv[0], {ch, 8'hA5}), rdat);
            bus(1'b0, OFS_IRQ, ZERO_WORD);
            chk("done_flag", 32'h1, 32'(rdat[IR_ADF]));
        end
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFS_IRQ, IRQW[i]);
            @(negedge sys_clk);
            chk("irq", (i == 0) ? 32'h1 : 32'h0, 32'(irq));
        end
        for (int f = 0; f < 2; f++) begin
            @(posedge sys_clk);
            amp <= 12'($urandom_range(12'hFF0, 12'h010));
            bus(1'b1, OFS_CTRL1, 32'h0000_0010);
            // Bounds are taken in the format in force when they are written.
            bus(1'b1, OFS_CTRL0, 32'h0000_0020 | (32'(f) << C0_FMT));
            bnd = exp_res(f[0], amp - 12'h001);
            bus(1'b1, OFS_HIBOUND, bnd);
            bus(1'b1, OFS_LOBOUND, bnd);
            for (int m = 0; m < 2; m++) begin
                bus(1'b1, OFS_TRIG, (m == 0) ? 32'h0000_0004 : 32'h0000_0008);
                bus(1'b1, OFS_IRQ, ZERO_WORD);
                conv({2'b00, 1'b1, f[0], 4'h0}, 0);
                bus(1'b0, OFS_IRQ, ZERO_WORD);
                chk("bound_flag", (m == 0) ? 32'h1 : 32'h0,
                    32'(rdat[IR_LIMF]));
                bus(1'b0, OFS_RESULT, ZERO_WORD);
                chk("amp_result", exp_res(f[0], amp), rdat);
            end
        end
        bus(1'b1, OFS_CTRL1, ZERO_WORD);
        dly = $urandom_range(10, 3);
        bus(1'b1, OFS_DELAY, 32'(dly));
        bus(1'b1, OFS_TRIG, 32'h0000_0003);
        bus(1'b1, OFS_CTRL0, 32'h0000_00A0);
        bus(1'b1, OFS_CTRL0, 32'h0000_0020);
        @(negedge sys_clk);
        chk("sw_start_off", 32'h0, 32'(smp));
        @(posedge sys_clk);
        pwm_ev <= 1'b1;
        @(posedge sys_clk);
        pwm_ev <= 1'b0;
        n = 0;
        while (smp !== 1'b1 && n < 100) begin
            n++;
            @(posedge sys_clk);
        end
        // The delay spans dly clocks; the poll sees sampling one edge later.
        chk("pwm_delay", 32'(dly + 1), 32'(n));
        repeat (60) @(posedge sys_clk);
        bus(1'b1, OFS_TRIG, ZERO_WORD);
        bus(1'b1, OFS_CTRL0, 32'h0000_0080);
        bus(1'b1, OFS_CTRL0, ZERO_WORD);
        @(negedge sys_clk);
        chk("power_off_start", 32'h0, 32'(smp));
        chk("power_off", 32'h0, 32'(actl.power_on));
        finish_test();
    end
endmodule
`default_nettype wire
